// >>> inc/spr_pkg.sv
// Constants and types shared by the serial port block and its helpers.
// Assumes a 100 MHz system clock and a serial clock pin that may stop between frames.
//
// What this block, its software and the external master do
// RULE1: Serial clock idles low at polarity 0 and high at polarity 1.
// RULE2: External master keeps the serial clock idle before soft reset release.
// RULE3: Slave stores each received byte and sets the receive flag; output starts at bit seven.
// RULE4: Slave in phase mode 1 sends its first byte exactly once.
// RULE5: Software treats two transmit flags without a receive flag as failure.
// RULE6: Setting then clearing the soft reset hold resets then re-enables the port.
// RULE7: In 4-pin master mode the select pin is conflict input or enable output.
// RULE8: In conflict mode software writes transmit data only while select is active.
// RULE9: Select going inactive aborts the transfer; rewritten data goes out later.
// RULE10: Phase select moves capture from the first to the second clock edge.
`default_nettype none
package spr_pkg;
  localparam int          SPR_DATA_W     = 8;
  localparam int          SPR_FIFO_DEPTH = 16;
  localparam int          SPR_CNT_W      = 3;
  localparam int          SPR_EDGE_W     = 4;
  localparam int          SPR_SYNC_W     = 4;
  localparam int          SPR_HALF_DIV   = 4;
  localparam int          SPR_HALF_W     = 8;
  // Slave select is active low on the pin
  localparam logic        SPR_SEL_ACTIVE = 1'b0;
  localparam logic [3:0]  SPR_LAST_EDGE  = 4'hF;
  localparam logic [2:0]  SPR_LAST_BIT   = 3'h7;
  localparam logic [2:0]  SPR_FIRST_BIT  = 3'h0;
  localparam logic [7:0]  SPR_RX_RESET   = 8'h00;
  localparam logic [7:0]  SPR_TX_RESET   = 8'h00;
  // Positions of the fields in the synchroniser bundle
  localparam int          SPR_SY_SEL     = 0;
  localparam int          SPR_SY_MISO    = 1;
  localparam int          SPR_SY_DONE    = 2;
  localparam int          SPR_SY_TAKE    = 3;

  typedef enum logic [0:0] {
    SPR_MS_IDLE = 1'b0,
    SPR_MS_RUN  = 1'b1
  } spr_master_e;
endpackage
`default_nettype wire

// >>> inc/spr_strm_if.sv
// Valid/ready word stream between the block's own modules.
// Assumes both ends run on the same clock.
`default_nettype none
interface spr_strm_if #(parameter int W = 8);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// >>> rtl/spr_sync.sv
// Two-flop synchroniser for a bundle of independent level signals.
// Assumes each bit is a level or a toggle that stays put for several clocks.
`default_nettype none
module spr_sync #(
  parameter int W = 4
) (
  input  wire logic         clk,
  input  wire logic         reset_n,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] sync_r;
  logic [W-1:0] sync_nxt;

  always_comb begin
    meta_nxt = async_in;
    sync_nxt = meta_r;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign sync_out = sync_r;
endmodule
`default_nettype wire

// >>> rtl/spr_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock; rst_n also flushes the contents.
`default_nettype none
module spr_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  input  wire logic clk,
  input  wire logic rst_n,
  spr_strm_if.snk   in_s,
  spr_strm_if.src   out_s
);
  localparam int AW = $clog2(D);
  localparam logic [AW:0]   DEPTH_C = (AW + 1)'(D);
  localparam logic [AW-1:0] LAST_C  = AW'(D - 1);

  logic [W-1:0]  mem_r [D];
  logic [AW-1:0] wr_r;
  logic [AW-1:0] wr_nxt;
  logic [AW-1:0] rd_r;
  logic [AW-1:0] rd_nxt;
  logic [AW:0]   cnt_r;
  logic [AW:0]   cnt_nxt;
  logic          push;
  logic          pop;

  assign in_s.ready  = (cnt_r != DEPTH_C);
  assign out_s.valid = (cnt_r != '0);
  assign out_s.data  = mem_r[rd_r];
  assign push        = in_s.valid && in_s.ready;
  assign pop         = out_s.valid && out_s.ready;

  always_comb begin
    wr_nxt  = wr_r;
    rd_nxt  = rd_r;
    cnt_nxt = cnt_r;
    if (push) begin
      wr_nxt = (wr_r == LAST_C) ? '0 : wr_r + 1'b1;
    end
    if (pop) begin
      rd_nxt = (rd_r == LAST_C) ? '0 : rd_r + 1'b1;
    end
    if (push && !pop) begin
      cnt_nxt = cnt_r + 1'b1;
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
    end else begin
      wr_r  <= wr_nxt;
      rd_r  <= rd_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // Storage needs no reset; empty count guards reads
  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wr_r] <= in_s.data;
    end
  end
endmodule
`default_nettype wire

// >>> rtl/spr_top.sv
// Serial peripheral port: master engine on clk, slave engine on the serial clock pin.
// Assumes mode and phase/polarity inputs change only while soft_reset_hold is high.
`default_nettype none
module spr_top
  import spr_pkg::*;
#(
  parameter int HALF_DIV = SPR_HALF_DIV,
  parameter int DEPTH    = SPR_FIFO_DEPTH
) (
  input  wire logic                  clk,
  input  wire logic                  reset_n,
  input  wire logic                  link_clk,
  input  wire logic                  master_mode,
  input  wire logic                  four_pin_mode,
  input  wire logic                  enable_pin_mode_select,
  input  wire logic                  clock_phase_select,
  input  wire logic                  clock_polarity_select,
  input  wire logic                  soft_reset_hold,
  input  wire logic [SPR_DATA_W-1:0] tx_data,
  input  wire logic                  tx_valid,
  output logic                       transmit_flag,
  output logic      [SPR_DATA_W-1:0] receive_buffer,
  output logic                       receive_flag,
  input  wire logic                  rx_read,
  output logic                       abort_flag,
  input  wire logic                  abort_clear,
  output logic                       sclk_out,
  output logic                       sclk_oe,
  input  wire logic                  mosi_in,
  output logic                       mosi_out,
  output logic                       mosi_oe,
  input  wire logic                  miso_in,
  output logic                       miso_out,
  output logic                       miso_oe,
  input  wire logic                  ste_in,
  output logic                       ste_out,
  output logic                       ste_oe
);
  localparam logic [SPR_HALF_W-1:0] HALF_LAST = SPR_HALF_W'(HALF_DIV - 1);

  logic                  run_n;
  logic [SPR_SYNC_W-1:0] sy_in;
  logic [SPR_SYNC_W-1:0] sy;
  logic                  sel_inactive;
  logic                  conflict_mode;

  // Soft reset hold flushes the FIFO and engine state in the clk domain; the synchroniser resets only on reset_n
  assign run_n = reset_n && !soft_reset_hold; // see RULE6

  spr_strm_if #(.W(SPR_DATA_W)) wr_s ();
  spr_strm_if #(.W(SPR_DATA_W)) rd_s ();

  assign wr_s.valid    = tx_valid;
  assign wr_s.data     = tx_data;
  assign transmit_flag = wr_s.ready && !soft_reset_hold;

  spr_fifo #(.W(SPR_DATA_W), .D(DEPTH)) spr_fifo_i (
    .clk   (clk),
    .rst_n (run_n),
    .in_s  (wr_s),
    .out_s (rd_s)
  );

  // Link-domain state seen from clk
  logic       s_done_tgl_r;
  logic       s_take_tgl_r;
  logic [7:0] s_word_r;

  assign sy_in[SPR_SY_SEL]  = ste_in;
  assign sy_in[SPR_SY_MISO] = miso_in;
  assign sy_in[SPR_SY_DONE] = s_done_tgl_r;
  assign sy_in[SPR_SY_TAKE] = s_take_tgl_r;

  spr_sync #(.W(SPR_SYNC_W)) spr_sync_i (
    .clk      (clk),
    .reset_n  (reset_n),
    .async_in (sy_in),
    .sync_out (sy)
  );

  assign sel_inactive  = (sy[SPR_SY_SEL] != SPR_SEL_ACTIVE);
  assign conflict_mode = four_pin_mode && !enable_pin_mode_select; // see RULE7

  // Holding word, master engine and receive side, all on clk
  spr_master_e           ms_r;
  spr_master_e           ms_nxt;
  logic [SPR_HALF_W-1:0] half_r;
  logic [SPR_HALF_W-1:0] half_nxt;
  logic [SPR_EDGE_W-1:0] edge_r;
  logic [SPR_EDGE_W-1:0] edge_nxt;
  logic                  lvl_r;
  logic                  lvl_nxt;
  logic [7:0]            mtx_r;
  logic [7:0]            mtx_nxt;
  logic [7:0]            mrx_r;
  logic [7:0]            mrx_nxt;
  logic [7:0]            hold_r;
  logic [7:0]            hold_nxt;
  logic                  hold_v_r;
  logic                  hold_v_nxt;
  logic                  done_seen_r;
  logic                  take_seen_r;
  logic [7:0]            rxb_r;
  logic [7:0]            rxb_nxt;
  logic                  rxf_r;
  logic                  rxf_nxt;
  logic                  abf_r;
  logic                  abf_nxt;
  logic                  leading;
  logic                  capture;
  logic                  m_done;
  logic                  m_abort;
  logic                  s_done;
  logic                  s_take;

  assign s_done = (sy[SPR_SY_DONE] != done_seen_r) && !master_mode;
  assign s_take = (sy[SPR_SY_TAKE] != take_seen_r) && !master_mode;
  assign rd_s.ready = !hold_v_r;

  always_comb begin
    ms_nxt     = ms_r;
    half_nxt   = half_r;
    edge_nxt   = edge_r;
    lvl_nxt    = lvl_r;
    mtx_nxt    = mtx_r;
    mrx_nxt    = mrx_r;
    hold_nxt   = hold_r;
    hold_v_nxt = hold_v_r;
    rxb_nxt    = rxb_r;
    rxf_nxt    = rxf_r;
    abf_nxt    = abf_r;
    m_done     = 1'b0;
    m_abort    = 1'b0;
    leading    = !edge_r[0];
    capture    = (leading != clock_phase_select); // see RULE10
    if (rd_s.valid && !hold_v_r) begin
      hold_nxt   = rd_s.data;
      hold_v_nxt = 1'b1;
    end
    if (s_take) begin
      hold_v_nxt = 1'b0;
    end
    unique case (ms_r)
      SPR_MS_IDLE: begin
        half_nxt = '0;
        edge_nxt = '0;
        lvl_nxt  = 1'b0;
        // A conflict input held inactive keeps the master from starting
        if (master_mode && hold_v_r && !(conflict_mode && sel_inactive)) begin
          mtx_nxt    = hold_r;
          hold_v_nxt = 1'b0;
          ms_nxt     = SPR_MS_RUN;
        end
      end
      SPR_MS_RUN: begin
        if (conflict_mode && sel_inactive) begin // see RULE9
          m_abort = 1'b1;
          lvl_nxt = 1'b0;
          ms_nxt  = SPR_MS_IDLE;
        end else if (half_r == HALF_LAST) begin
          half_nxt = '0;
          edge_nxt = edge_r + 1'b1;
          lvl_nxt  = !lvl_r;
          if (capture) begin
            mrx_nxt = {mrx_r[6:0], sy[SPR_SY_MISO]};
          end else if (!(clock_phase_select && edge_r == '0)) begin
            mtx_nxt = {mtx_r[6:0], 1'b0};
          end
          if (edge_r == SPR_LAST_EDGE) begin
            m_done = 1'b1;
            ms_nxt = SPR_MS_IDLE;
          end
        end else begin
          half_nxt = half_r + 1'b1;
        end
      end
    endcase
    if (m_done) begin
      rxb_nxt = mrx_nxt;
    end else if (s_done) begin
      rxb_nxt = s_word_r; // see RULE3
    end
    // A new byte wins over a read in the same cycle
    if (rx_read) begin
      rxf_nxt = 1'b0;
    end
    if (m_done || s_done) begin
      rxf_nxt = 1'b1; // see RULE3
    end
    if (abort_clear) begin
      abf_nxt = 1'b0;
    end
    if (m_abort) begin
      abf_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!run_n) begin
      ms_r        <= SPR_MS_IDLE;
      half_r      <= '0;
      edge_r      <= '0;
      lvl_r       <= 1'b0;
      mtx_r       <= SPR_TX_RESET;
      mrx_r       <= SPR_RX_RESET;
      hold_r      <= SPR_TX_RESET;
      hold_v_r    <= 1'b0;
      done_seen_r <= 1'b0;
      take_seen_r <= 1'b0;
      rxb_r       <= SPR_RX_RESET;
      rxf_r       <= 1'b0;
      abf_r       <= 1'b0;
    end else begin
      ms_r        <= ms_nxt;
      half_r      <= half_nxt;
      edge_r      <= edge_nxt;
      lvl_r       <= lvl_nxt;
      mtx_r       <= mtx_nxt;
      mrx_r       <= mrx_nxt;
      hold_r      <= hold_nxt;
      hold_v_r    <= hold_v_nxt;
      done_seen_r <= sy[SPR_SY_DONE];
      take_seen_r <= sy[SPR_SY_TAKE];
      rxb_r       <= rxb_nxt;
      rxf_r       <= rxf_nxt;
      abf_r       <= abf_nxt;
    end
  end

  assign receive_buffer = rxb_r;
  assign receive_flag   = rxf_r;
  assign abort_flag     = abf_r;

  // Master pins; the clock rests at the polarity level between bytes
  assign sclk_out = clock_polarity_select ^ lvl_r; // see RULE1
  assign sclk_oe  = master_mode && !(conflict_mode && sel_inactive);
  assign mosi_out = mtx_r[7];
  assign mosi_oe  = sclk_oe;
  assign ste_out  = (ms_r == SPR_MS_IDLE) ? !SPR_SEL_ACTIVE : SPR_SEL_ACTIVE;
  assign ste_oe   = master_mode && four_pin_mode && enable_pin_mode_select; // see RULE7

  // Slave engine: the capture edge is made a rising edge so one process serves all modes.
  // Cleared asynchronously because the pin clock gives no edge once select goes away.
  logic       cap_clk;
  logic       link_clr_n;
  logic       link_run_n;
  logic       sel_pin_active;
  logic [2:0] s_cnt_r;
  logic [2:0] s_cnt_nxt;
  logic       s_start_r;
  logic       s_start_nxt;
  logic [6:0] s_sh_r;
  logic [6:0] s_sh_nxt;
  logic [7:0] s_word_nxt;
  logic       s_done_nxt;
  logic       s_take_nxt;
  logic [7:0] s_shadow_r;
  logic [7:0] s_shadow_nxt;
  logic       s_miso_r;
  logic       s_miso_nxt;

  assign cap_clk        = link_clk ^ (clock_polarity_select ^ clock_phase_select); // see RULE10
  assign sel_pin_active = !four_pin_mode || (ste_in == SPR_SEL_ACTIVE);
  assign link_clr_n     = run_n && !master_mode && sel_pin_active; // see RULE6
  assign link_run_n     = run_n && !master_mode;

  always_comb begin
    s_cnt_nxt    = s_cnt_r + 1'b1;
    s_start_nxt  = 1'b1;
    s_sh_nxt     = {s_sh_r[5:0], mosi_in};
    s_word_nxt   = s_word_r;
    s_done_nxt   = s_done_tgl_r;
    s_take_nxt   = s_take_tgl_r;
    s_shadow_nxt = s_shadow_r;
    if (s_cnt_r == SPR_LAST_BIT) begin
      s_word_nxt = {s_sh_r, mosi_in}; // see RULE3
      s_done_nxt = !s_done_tgl_r;
    end
    // Taking the word once per byte start keeps the first byte from repeating
    if (s_cnt_r == SPR_FIRST_BIT && sel_pin_active) begin
      s_shadow_nxt = hold_r; // see RULE4
      s_take_nxt   = !s_take_tgl_r;
    end
    s_miso_nxt = (s_cnt_r == SPR_FIRST_BIT) ? hold_r[7] : s_shadow_r[3'h7 - s_cnt_r];
  end

  always_ff @(posedge cap_clk or negedge link_clr_n) begin
    if (!link_clr_n) begin
      s_cnt_r      <= SPR_FIRST_BIT;
      s_start_r    <= 1'b0;
      s_sh_r       <= '0;
      s_shadow_r   <= SPR_TX_RESET;
    end else begin
      s_cnt_r      <= s_cnt_nxt;
      s_start_r    <= s_start_nxt;
      s_sh_r       <= s_sh_nxt;
      s_shadow_r   <= s_shadow_nxt;
    end
  end

  // Toggles survive select going away; clearing them there would fake a second event
  always_ff @(posedge cap_clk or negedge link_run_n) begin
    if (!link_run_n) begin
      s_word_r     <= SPR_RX_RESET;
      s_done_tgl_r <= 1'b0;
      s_take_tgl_r <= 1'b0;
    end else begin
      s_word_r     <= s_word_nxt;
      s_done_tgl_r <= s_done_nxt;
      s_take_tgl_r <= s_take_nxt;
    end
  end

  // Launch on the other edge; phase 1 launches the first bit on the leading edge
  always_ff @(negedge cap_clk or negedge link_clr_n) begin
    if (!link_clr_n) begin
      s_miso_r <= 1'b0;
    end else begin
      s_miso_r <= s_miso_nxt; // see RULE4
    end
  end

  // Phase 0 needs the first bit before any edge arrives
  assign miso_out = (!clock_phase_select && !s_start_r) ? hold_r[7] : s_miso_r; // see RULE3
  assign miso_oe  = !master_mode && sel_pin_active && !soft_reset_hold;
endmodule
`default_nettype wire

// >>> test/spr_checker.sv
// Checker for the serial port top: timing relations between its pins.
// Assumes it is bound to every spr_top and that all pins are on clk.
`default_nettype none
module spr_checker (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic master_mode,
  input wire logic four_pin_mode,
  input wire logic enable_pin_mode_select,
  input wire logic clock_polarity_select,
  input wire logic soft_reset_hold,
  input wire logic transmit_flag,
  input wire logic receive_flag,
  input wire logic rx_read,
  input wire logic abort_flag,
  input wire logic abort_clear,
  input wire logic sclk_out,
  input wire logic sclk_oe,
  input wire logic miso_oe,
  input wire logic ste_in,
  input wire logic ste_out,
  input wire logic ste_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Conflict mode: the select pin is an input that can stop this master
  wire logic cfl = master_mode && four_pin_mode && !enable_pin_mode_select;

  idle_level_a: assert property (
    master_mode && ste_out |-> sclk_out == clock_polarity_select)
    else $error("serial clock away from idle level");
  hold_flags_a: assert property (
    soft_reset_hold [*2] |-> !receive_flag && !abort_flag && !transmit_flag)
    else $error("flags alive under soft hold");
  release_ready_a: assert property (
    $fell(soft_reset_hold) |-> transmit_flag)
    else $error("port not ready after soft hold");
  ste_role_a: assert property (
    ste_oe == (master_mode && four_pin_mode && enable_pin_mode_select))
    else $error("select pin role wrong");
  conflict_stop_a: assert property (
    (cfl && ste_in) [*4] |-> !sclk_oe && ste_out)
    else $error("master drives while select inactive");
  abort_set_a: assert property (
    $rose(ste_in) && cfl && !ste_out && !soft_reset_hold
      && sclk_out != clock_polarity_select |-> ##[1:5] abort_flag)
    else $error("abort not flagged");
  abort_sticky_a: assert property (
    abort_flag && !abort_clear && !soft_reset_hold |=> abort_flag)
    else $error("abort flag lost");
  rx_sticky_a: assert property (
    receive_flag && !rx_read && !soft_reset_hold |=> receive_flag)
    else $error("receive flag lost");
  miso_role_a: assert property (
    master_mode || soft_reset_hold |-> !miso_oe)
    else $error("slave output driven");
endmodule
bind spr_top spr_checker spr_checker_i (.*);
`default_nettype wire

// >>> test/spr_far.sv
// Far side: external master for slave tests, echoing slave for master tests.
// Assumes the bench calls xfer between its own frames and sets ext_ste otherwise.
`default_nettype none
module spr_far (
  input  wire logic clock_phase_select,
  input  wire logic clock_polarity_select,
  input  wire logic ext_ste,
  input  wire logic sclk_oe,
  input  wire logic mosi_out,
  input  wire logic miso_out,
  output logic      link_clk,
  output logic      mosi_in,
  output logic      miso_in,
  output logic      ste_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic act = 1'b0;
  logic fr  = 1'b0;
  logic mo  = 1'b0;
  // Clock stands at idle level outside frames, also across soft hold release
  assign link_clk = clock_polarity_select ^ act;
  assign ste_in   = fr ? 1'b0 : ext_ste;
  assign mosi_in  = mo;
  // Echo inverts; a released line flips so a stale bit never matches
  assign miso_in  = mosi_out ^ sclk_oe;

  task automatic xfer(input logic [7:0] d, output logic [7:0] q);
    fr = 1'b1;
    for (int i = 7; i >= 0; i--) begin
      if (!clock_phase_select) mo = d[i];
      #32 act = 1'b1;
      if (clock_phase_select) mo = d[i];
      else q[i] = miso_out;
      #32 act = 1'b0;
      if (clock_phase_select) q[i] = miso_out;
    end
    #32 fr = 1'b0;
    mo = ~mo;
  endtask
endmodule
`default_nettype wire

// >>> test/spi_port_reset_and_select_bench.sv
// Bench for the serial port: master modes, buffer fill, abort, soft hold, slave.
// Assumes spr_top, spr_far and the bound checker are compiled before it.
`default_nettype none
module spi_port_reset_and_select_bench
  import spr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, reset_n, link_clk, master_mode, four_pin_mode, enable_pin_mode_select;
  logic clock_phase_select, clock_polarity_select, soft_reset_hold, tx_valid, rx_read;
  logic transmit_flag, receive_flag, abort_flag, abort_clear, sclk_out, sclk_oe;
  logic mosi_in, mosi_out, mosi_oe, miso_in, miso_out, miso_oe, ste_in, ste_out, ste_oe;
  logic ext_ste;
  logic [SPR_DATA_W-1:0] tx_data, receive_buffer, a, b, d, r;
  logic [7:0]  q[$];
  logic [31:0] seed = 32'h29CED529;
  int          miscompares = 0;
  int          n_checks = 0;
  int          cyc = 0;

  spr_top #(.HALF_DIV(SPR_HALF_DIV), .DEPTH(SPR_FIFO_DEPTH)) spr_top_i (.*);
  spr_far spr_far_i (.*);

  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  // The far slave echoes every bit inverted
  function automatic logic [7:0] echo(input logic [7:0] x);
    return ~x;
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    if (miscompares == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic cfg(input logic m, e, ph, pl);
    soft_reset_hold <= 1'b1;
    master_mode <= m;
    enable_pin_mode_select <= e;
    clock_phase_select <= ph;
    clock_polarity_select <= pl;
    repeat (3) @(posedge clk);
    soft_reset_hold <= 1'b0;
    @(posedge clk);
  endtask
  task automatic put_tx(input logic [7:0] v);
    tx_data <= v;
    tx_valid <= 1'b1;
    do @(posedge clk); while (transmit_flag !== 1'b1);
    tx_valid <= 1'b0;
    @(posedge clk);
  endtask
  task automatic get_rx(input logic [7:0] exp);
    for (int i = 0; i < 300 && receive_flag !== 1'b1; i++) @(posedge clk);
    chk({7'h00, receive_flag}, 8'h01);
    chk(receive_buffer, exp);
    rx_read <= 1'b1;
    @(posedge clk);
    rx_read <= 1'b0;
    @(posedge clk);
  endtask
  task automatic mid_frame();
    for (int i = 0; i < 60 && sclk_out === clock_polarity_select; i++) @(posedge clk);
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      miscompares++;
      final_report();
    end
  end

  initial begin
    reset_n = 1'b0;
    master_mode = 1'b1;
    four_pin_mode = 1'b1;
    enable_pin_mode_select = 1'b1;
    clock_phase_select = 1'b0;
    clock_polarity_select = 1'b0;
    soft_reset_hold = 1'b1;
    tx_data = 8'h00;
    tx_valid = 1'b0;
    rx_read = 1'b0;
    abort_clear = 1'b0;
    ext_ste = 1'b1;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk);
    chk({5'h00, transmit_flag, receive_flag, abort_flag}, 8'h00);
    for (int k = 0; k < 4; k++) begin
      cfg(1'b1, 1'b1, k[0], k[1]);
      chk({7'h00, sclk_out}, {7'h00, clock_polarity_select});
      d = rnd();
      put_tx(d);
      get_rx(echo(d));
    end
    // Back-to-back writes until the buffer refuses, then drain it
    q = {};
    tx_data <= rnd();
    tx_valid <= 1'b1;
    repeat (30) begin
      @(posedge clk);
      if (transmit_flag === 1'b1) begin
        q.push_back(tx_data);
        tx_data <= rnd();
      end
    end
    tx_valid <= 1'b0;
    chk({7'h00, transmit_flag}, 8'h00);
    foreach (q[i]) get_rx(echo(q[i]));
    cfg(1'b1, 1'b0, 1'b0, 1'b0);
    ext_ste <= 1'b0;
    @(posedge clk);
    d = rnd();
    put_tx(d);
    mid_frame();
    ext_ste <= 1'b1;
    repeat (8) @(posedge clk);
    chk({6'h00, abort_flag, receive_flag}, 8'h02);
    abort_clear <= 1'b1;
    ext_ste <= 1'b0;
    @(posedge clk);
    abort_clear <= 1'b0;
    put_tx(d);
    get_rx(echo(d));
    chk({7'h00, abort_flag}, 8'h00);
    cfg(1'b1, 1'b1, 1'b1, 1'b1);
    put_tx(rnd());
    mid_frame();
    soft_reset_hold <= 1'b1;
    repeat (2) @(posedge clk);
    chk({6'h00, transmit_flag, receive_flag}, 8'h00);
    soft_reset_hold <= 1'b0;
    repeat (2) @(posedge clk);
    chk({7'h00, sclk_out}, 8'h01);
    d = rnd();
    put_tx(d);
    get_rx(echo(d));
    ext_ste <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      cfg(1'b0, 1'b0, k[0], k[1]);
      a = rnd();
      b = rnd();
      put_tx(a);
      put_tx(b);
      d = rnd();
      spr_far_i.xfer(d, r);
      chk(r, a);
      get_rx(d);
      spr_far_i.xfer(~d, r);
      chk(r, b);
      get_rx(~d);
    end
    final_report();
  end
endmodule
`default_nettype wire
